//--- hw/icd_top.sv
// Command decoder of an eight-level vectored interrupt controller
//
// How it works
// - Vector writes unlimited by byte count; count sets reads and interrupts.
// - Vectors are returned during acknowledge in the order written.
// - Three-bit select field decodes binary 0..7 to the target bit.
// - Clear-all request-and-mask clears both registers entirely.
// - Single clear request-and-mask clears only the selected bits.
// - Mask commands: clear all, clear one, set all, set one.
// - Request commands: clear all, clear one, set all, set one.
// - Clear highest priority in-service bit; low four bits ignored.
// - Clear all in-service bits, or one selected bit.
// - Load-low-mode copies command bits 0..4 into mode bits 0..4.
// - Upper-mode loads bits 5,6; low bits keep, set, clear bit 7.
// - Mode bit 7 is master mask; control code 11 is illegal.
// - Preselect-mask routes later data writes into the mask register.
// - Preselect-auxiliary routes later data writes into auxiliary control.
// - Vector preselect loads level byte count and targets that level.
// - Don't-care command bits are ignored during decode.
// - Bus address compared to base set by nine straps.
// - One strap picks which port A upper signals make requests.
`timescale 1ns/1ps
module icd_top (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  input  wire logic [8:0]  address_strap,
  input  wire logic        irq_source_strap,
  input  wire logic [7:0]  port_a_hi,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq,
  output logic             int_req
);
  logic [7:0]         interrupt_request_reg;
  logic [7:0]         interrupt_mask_reg;
  logic [7:0]         in_service_reg;
  logic [7:0]         mode_reg;
  logic [7:0]         auxiliary_control_reg;
  logic [1:0]         byte_count [0:7];
  logic [2:0]         level_sel;
  icd_pkg::icd_sel_t  sel;
  logic [3:0]         evt;
  logic [3:0]         evt_mask;
  logic [7:0]         src_q;
  logic [2:0]         ack_level;
  logic               ack_active;

  // Bus decode
  wire        base_hit = paddr[16:8] == address_strap;
  wire [7:0]  off      = paddr[7:0];
  wire        acc      = psel && penable && clk_en && pready && base_hit;
  wire        wr       = acc && pwrite && pstrb[0];
  wire        rd       = acc && !pwrite;
  wire        cmd_wr   = wr && off == icd_pkg::OFF_CMD;
  wire        dat_wr   = wr && off == icd_pkg::OFF_DATA;
  wire        iak_rd   = rd && off == icd_pkg::OFF_IAK;
  wire        evt_wr   = wr && off == icd_pkg::OFF_EVT;
  wire        emsk_wr  = wr && off == icd_pkg::OFF_EVT_MSK;
  wire        mapped   = off <= icd_pkg::OFF_CFG && off[1:0] == 2'h0;
  wire [7:0]  c        = pwdata[7:0];
  wire [7:0]  bsel     = icd_pkg::icd_onehot(c[2:0]);

  // Command class decode, only defined bits compared
  wire c_clr_rm_all = c[7:3] == 5'b00010;
  wire c_clr_rm_one = c[7:3] == 5'b00011;
  wire c_clr_m_all  = c[7:3] == 5'b00100;
  wire c_clr_m_one  = c[7:3] == 5'b00101;
  wire c_set_m_all  = c[7:3] == 5'b00110;
  wire c_set_m_one  = c[7:3] == 5'b00111;
  wire c_clr_r_all  = c[7:3] == 5'b01000;
  wire c_clr_r_one  = c[7:3] == 5'b01001;
  wire c_set_r_all  = c[7:3] == 5'b01010;
  wire c_set_r_one  = c[7:3] == 5'b01011;
  wire c_clr_s_hi   = c[7:4] == 4'b0110;
  wire c_clr_s_all  = c[7:3] == 5'b01110;
  wire c_clr_s_one  = c[7:3] == 5'b01111;
  wire c_reset      = c == 8'h00;
  wire c_mode_lo    = c[7:5] == 3'b100;
  wire c_mode_hi    = c[7:4] == 4'b1010;
  wire c_pre_imr    = c[7:4] == 4'b1011;
  wire c_pre_acr    = c[7:4] == 4'b1100;
  wire c_pre_vec    = c[7:5] == 3'b111;
  wire c_illegal    = c_mode_hi && c[1:0] == 2'b11;
  wire c_known = c_clr_rm_all | c_clr_rm_one | c_clr_m_all | c_clr_m_one |
                 c_set_m_all | c_set_m_one | c_clr_r_all | c_clr_r_one |
                 c_set_r_all | c_set_r_one | c_clr_s_hi | c_clr_s_all |
                 c_clr_s_one | c_reset | c_mode_lo | c_pre_imr |
                 c_pre_acr | c_pre_vec | (c_mode_hi && !c_illegal);

  // Mask register next value
  wire [7:0] m_clr = (c_clr_rm_all | c_clr_m_all) ? 8'hff :
                     (c_clr_rm_one | c_clr_m_one) ? bsel : 8'h00;
  wire [7:0] m_set = c_set_m_all ? 8'hff : c_set_m_one ? bsel : 8'h00;
  wire [7:0] next_imr_cmd = (interrupt_mask_reg & ~m_clr) | m_set;

  // Request register edits
  wire [7:0] r_clr = (c_clr_rm_all | c_clr_r_all) ? 8'hff :
                     (c_clr_rm_one | c_clr_r_one) ? bsel : 8'h00;
  wire [7:0] r_set = c_set_r_all ? 8'hff : c_set_r_one ? bsel : 8'h00;

  // Request sources picked by strap
  wire [7:0] src = irq_source_strap ? {4'h0, port_a_hi[3:0]} : port_a_hi;
  wire [7:0] src_rise = src & ~src_q;

  // Priority resolution
  wire [7:0] pend = interrupt_request_reg & ~interrupt_mask_reg;
  wire [7:0] isr_first;
  wire [2:0] isr_idx;
  wire       isr_any;
  wire [7:0] pend_first;
  wire [2:0] pend_idx;
  wire       pend_any;

  icd_prio u_isr_prio (
    .bits  (in_service_reg),
    .first (isr_first),
    .index (isr_idx),
    .any   (isr_any)
  );

  icd_prio u_pend_prio (
    .bits  (pend),
    .first (pend_first),
    .index (pend_idx),
    .any   (pend_any)
  );

  // Acknowledge serves pending level, or continues current multi-byte one
  wire [2:0] iak_level = ack_active ? ack_level : pend_idx;
  wire       iak_ok    = ack_active || pend_any;
  wire [7:0] vec_data;
  wire       vec_last;
  wire       iak_avail = iak_ok && !mode_reg[icd_pkg::MASTER_MASK];
  wire       vec_rd    = iak_rd && iak_avail;

  icd_vec_mem u_vec (
    .pclk       (pclk),
    .presetn    (presetn),
    .en         (clk_en),
    .wr         (dat_wr && sel == icd_pkg::ICD_SEL_VEC),
    .wr_level   (dat_wr ? level_sel : c[2:0]),
    .restart    (cmd_wr && c_pre_vec),
    .wr_data    (c),
    .rd         (vec_rd),
    .rd_level   (iak_level),
    .count_code (byte_count[iak_level]),
    .rd_data    (vec_data),
    .rd_last    (vec_last)
  );

  // Master mask gates the request line
  wire       next_int_req = pend_any && !mode_reg[icd_pkg::MASTER_MASK];
  wire [3:0] ev_raw = {1'b0, dat_wr, cmd_wr && !c_known, cmd_wr};
  wire [3:0] ev_clr = evt_wr ? pwdata[3:0] : 4'h0;
  wire [3:0] next_evt = (evt & ~ev_clr) | ev_raw;

  wire [31:0] rd_mux =
    off == icd_pkg::OFF_IRR     ? {24'h0, interrupt_request_reg} :
    off == icd_pkg::OFF_IMR     ? {24'h0, interrupt_mask_reg} :
    off == icd_pkg::OFF_ISR     ? {24'h0, in_service_reg} :
    off == icd_pkg::OFF_MODE    ? {24'h0, mode_reg} :
    off == icd_pkg::OFF_ACR     ? {24'h0, auxiliary_control_reg} :
    off == icd_pkg::OFF_IAK     ? (iak_avail ? {24'h0, vec_data} : 32'h0) :
    off == icd_pkg::OFF_EVT     ? {28'h0, evt} :
    off == icd_pkg::OFF_EVT_MSK ? {28'h0, evt_mask} :
    off == icd_pkg::OFF_CFG     ? {21'h0, level_sel, 6'h0, sel} : 32'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      interrupt_request_reg <= icd_pkg::RST_BYTE;
      interrupt_mask_reg    <= icd_pkg::RST_MASK;
      in_service_reg        <= icd_pkg::RST_BYTE;
      mode_reg              <= icd_pkg::RST_BYTE;
      auxiliary_control_reg <= icd_pkg::RST_BYTE;
      sel                   <= icd_pkg::ICD_SEL_NONE;
      level_sel             <= 3'h0;
      src_q                 <= icd_pkg::RST_BYTE;
      ack_active            <= 1'b0;
      ack_level             <= 3'h0;
      for (int i = 0; i < icd_pkg::LEVELS; i++)
        byte_count[i] <= 2'h0;
    end else if (clk_en) begin
      src_q <= src;
      // Hardware edge sets win over command clears
      if (cmd_wr)
        interrupt_request_reg <= (interrupt_request_reg & ~r_clr) | r_set
                                 | src_rise;
      // First acknowledge of a level moves its request to in-service
      else if (vec_rd && !ack_active)
        interrupt_request_reg <= (interrupt_request_reg & ~pend_first)
                                 | src_rise;
      else
        interrupt_request_reg <= interrupt_request_reg | src_rise;
      if (cmd_wr)
        interrupt_mask_reg <= next_imr_cmd;
      else if (dat_wr && sel == icd_pkg::ICD_SEL_IMR)
        interrupt_mask_reg <= c;
      if (dat_wr && sel == icd_pkg::ICD_SEL_ACR)
        auxiliary_control_reg <= c;
      if (cmd_wr && c_clr_s_hi)
        in_service_reg <= in_service_reg & ~isr_first;
      else if (cmd_wr && c_clr_s_all)
        in_service_reg <= 8'h00;
      else if (cmd_wr && c_clr_s_one)
        in_service_reg <= in_service_reg & ~bsel;
      else if (vec_rd && !ack_active)
        in_service_reg <= in_service_reg | pend_first;
      if (cmd_wr && c_mode_lo)
        mode_reg[4:0] <= c[4:0];
      if (cmd_wr && c_mode_hi && !c_illegal) begin
        mode_reg[6:5] <= c[3:2];
        if (c[1:0] == 2'b01)
          mode_reg[icd_pkg::MASTER_MASK] <= 1'b1;
        else if (c[1:0] == 2'b10)
          mode_reg[icd_pkg::MASTER_MASK] <= 1'b0;
      end
      if (cmd_wr && c_known)
        sel <= c_pre_imr ? icd_pkg::ICD_SEL_IMR :
               c_pre_acr ? icd_pkg::ICD_SEL_ACR :
               c_pre_vec ? icd_pkg::ICD_SEL_VEC : icd_pkg::ICD_SEL_NONE;
      if (cmd_wr && c_pre_vec) begin
        byte_count[c[2:0]] <= c[4:3];
        level_sel          <= c[2:0];
      end
      // Multi-byte acknowledge spans count reads
      if (vec_rd) begin
        ack_active <= !vec_last;
        ack_level  <= iak_level;
      end
    end
  end

  // Bus answer registers and output flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0;
      pslverr <= 1'b0;
      evt     <= 4'h0;
      evt_mask <= 4'h0;
      irq     <= 1'b0;
      int_req <= 1'b0;
    end else if (clk_en) begin
      pready  <= psel && !penable;
      prdata  <= (psel && !penable && !pwrite) ? rd_mux : prdata;
      pslverr <= psel && !penable && !(base_hit && mapped);
      evt     <= next_evt;
      if (emsk_wr)
        evt_mask <= pwdata[3:0];
      irq     <= |(next_evt & evt_mask);
      int_req <= next_int_req;
    end
  end

  chk_clear_all_rm: assert property (@(posedge pclk) disable iff (!presetn)
    cmd_wr && c_clr_rm_all |=> interrupt_mask_reg == 8'h00)
    else $error("mask not cleared by clear-all");
  chk_single_clear: assert property (@(posedge pclk) disable iff (!presetn)
    cmd_wr && c_clr_m_one |=> interrupt_mask_reg ==
      ($past(interrupt_mask_reg) & ~$past(bsel)))
    else $error("single mask clear wrong");
  chk_set_mask: assert property (@(posedge pclk) disable iff (!presetn)
    cmd_wr && c_set_m_one |=> interrupt_mask_reg[$past(c[2:0])])
    else $error("mask bit not set");
  chk_set_req: assert property (@(posedge pclk) disable iff (!presetn)
    cmd_wr && c_set_r_all |=> interrupt_request_reg == 8'hff)
    else $error("request set-all failed");
  chk_isr_high: assert property (@(posedge pclk) disable iff (!presetn)
    cmd_wr && c_clr_s_hi && isr_any |=>
      in_service_reg == ($past(in_service_reg) & ~$past(isr_first)))
    else $error("highest in-service not cleared");
  chk_isr_all: assert property (@(posedge pclk) disable iff (!presetn)
    cmd_wr && c_clr_s_all |=> in_service_reg == 8'h00)
    else $error("in-service not cleared");
  chk_mode_lo: assert property (@(posedge pclk) disable iff (!presetn)
    cmd_wr && c_mode_lo |=> mode_reg[4:0] == $past(c[4:0]))
    else $error("low mode load wrong");
  chk_mode_m7: assert property (@(posedge pclk) disable iff (!presetn)
    cmd_wr && c_mode_hi && c[1:0] == 2'b11 |=> $stable(mode_reg))
    else $error("illegal mode command acted");
  chk_preselect: assert property (@(posedge pclk) disable iff (!presetn)
    dat_wr && sel == icd_pkg::ICD_SEL_ACR |=>
      auxiliary_control_reg == $past(c))
    else $error("aux data write lost");
endmodule : icd_top

//--- hw/icd_pkg.sv
// Constants and types for the interrupt command decoder
package icd_pkg;

  // Register word offsets on APB
  localparam logic [7:0] OFF_CMD     = 8'h00;
  localparam logic [7:0] OFF_DATA    = 8'h04;
  localparam logic [7:0] OFF_IRR     = 8'h08;
  localparam logic [7:0] OFF_IMR     = 8'h0c;
  localparam logic [7:0] OFF_ISR     = 8'h10;
  localparam logic [7:0] OFF_MODE    = 8'h14;
  localparam logic [7:0] OFF_ACR     = 8'h18;
  localparam logic [7:0] OFF_IAK     = 8'h1c;
  localparam logic [7:0] OFF_EVT     = 8'h20;
  localparam logic [7:0] OFF_EVT_MSK = 8'h24;
  localparam logic [7:0] OFF_CFG     = 8'h28;

  // Base address compare: nine straps against paddr[16:8]
  localparam int         BASE_LSB    = 8;
  localparam int         BASE_W      = 9;
  localparam int         OFF_W       = 8;

  localparam int         LEVELS      = 8;
  localparam int         VEC_DEPTH   = 4;
  localparam int         MASTER_MASK = 7;

  // Event bit positions
  localparam int         EV_CMD      = 0;
  localparam int         EV_BADCMD   = 1;
  localparam int         EV_DATA     = 2;
  localparam int         EV_W        = 3;

  localparam logic [7:0] RST_BYTE    = 8'h00;
  localparam logic [7:0] RST_MASK    = 8'hff;

  typedef enum logic [1:0] {
    ICD_SEL_NONE,
    ICD_SEL_IMR,
    ICD_SEL_ACR,
    ICD_SEL_VEC
  } icd_sel_t;

  // Select-field decode to a one-hot bit
  function automatic logic [7:0] icd_onehot(input logic [2:0] b);
    icd_onehot = 8'h01 << b;
  endfunction : icd_onehot

endpackage : icd_pkg

//--- hw/icd_vec_mem.sv
// Per-level vector memory, read back in entry order
`timescale 1ns/1ps
module icd_vec_mem (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       en,
  input  wire logic       wr,
  input  wire logic [2:0] wr_level,
  input  wire logic       restart,
  input  wire logic [7:0] wr_data,
  input  wire logic       rd,
  input  wire logic [2:0] rd_level,
  input  wire logic [1:0] count_code,
  output logic      [7:0] rd_data,
  output logic            rd_last
);
  logic [7:0] mem [0:7][0:3];
  logic [1:0] wptr [0:7];
  logic [1:0] rptr [0:7];
  logic [1:0] cur_rptr;

  assign cur_rptr = rptr[rd_level];
  assign rd_data  = mem[rd_level][cur_rptr];
  // Count code 0..3 means 1..4 vectors
  assign rd_last  = (cur_rptr == count_code);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 8; i++) begin
        wptr[i] <= 2'h0;
        rptr[i] <= 2'h0;
      end
    end else if (en) begin
      if (restart)
        wptr[wr_level] <= 2'h0;
      // Writes are not limited by the count; pointer wraps
      else if (wr)
        wptr[wr_level] <= wptr[wr_level] + 2'h1;
      if (rd)
        rptr[rd_level] <= rd_last ? 2'h0 : cur_rptr + 2'h1;
    end
  end

  always_ff @(posedge pclk) begin
    if (en && wr && !restart)
      mem[wr_level][wptr[wr_level]] <= wr_data;
  end
endmodule : icd_vec_mem

//--- hw/icd_prio.sv
// Highest priority set bit finder, bit 0 highest
`timescale 1ns/1ps
module icd_prio (
  input  wire logic [7:0] bits,
  output logic      [7:0] first,
  output logic      [2:0] index,
  output logic            any
);
  assign any   = |bits;
  // Lowest set bit isolates highest priority
  assign first = bits & (~bits + 8'h01);
  assign index = first[1] ? 3'h1 : first[2] ? 3'h2 : first[3] ? 3'h3 :
                 first[4] ? 3'h4 : first[5] ? 3'h5 : first[6] ? 3'h6 :
                 first[7] ? 3'h7 : 3'h0;
endmodule : icd_prio

//--- test/icd_host.sv
// Host model: APB master issuing commands, data and acknowledges
`timescale 1ns/1ps
module icd_host #(
  parameter logic [31:0] BASE = 32'h0
) (
  input  wire logic        pclk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [31:0] paddr,
  output logic      [31:0] pwdata,
  output logic      [3:0]  pstrb,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  logic [31:0] rdata;
  logic        err;

  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 32'h0;
    pwdata  = 32'h0;
    pstrb   = 4'hf;
  end

  // Request held until pready is seen at a falling edge
  task automatic xfer(input logic w, input logic [31:0] a,
                      input logic [31:0] d);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Answer looked at mid-cycle, where it is settled
    @(negedge pclk);
    while (pready !== 1'b1) @(negedge pclk);
    rdata = prdata;
    err   = pslverr;
    @(posedge pclk);
    psel    <= 1'b0;
    penable <= 1'b0;
    // Released data lines must not look like valid data
    pwdata  <= ~d;
  endtask : xfer

  // Stale entries would come out as vectors, so write exactly the count
  task automatic load_vectors(input logic [1:0] code, input logic [2:0] lvl,
                              input logic [7:0] v [4]);
    xfer(1'b1, BASE | 32'(icd_pkg::OFF_CMD), {24'h0, 3'b111, code, lvl});
    for (int i = 0; i <= int'(code); i++) begin
      xfer(1'b1, BASE | 32'(icd_pkg::OFF_DATA), {24'h0, v[i]});
    end
  endtask : load_vectors
endmodule : icd_host

//--- test/tb.sv
// Self-checking bench for the interrupt command decoder
`timescale 1ns/1ps
module tb;
  localparam logic [8:0]  STRAP = 9'h0a5;
  localparam logic [31:0] BASE  = {15'h0, STRAP, 8'h00};
  logic        pclk;
  logic        presetn;
  logic        irq_source_strap;
  logic [7:0]  port_a_hi;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] paddr;
  logic [31:0] pwdata;
  logic [3:0]  pstrb;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        irq;
  logic        int_req;
  logic [7:0]  vec [4];
  int          errors;
  int          checks_done;

  always #5 pclk = ~pclk;

  icd_top dut (
    .pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .address_strap(STRAP),
    .irq_source_strap(irq_source_strap), .port_a_hi(port_a_hi),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .int_req(int_req)
  );

  icd_host #(.BASE(BASE)) host (
    .pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr)
  );

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] off, input logic [31:0] d);
    host.xfer(1'b1, BASE | {24'h0, off}, d);
  endtask : wr

  task automatic rd(input logic [7:0] off, input logic [31:0] exp);
    host.xfer(1'b0, BASE | {24'h0, off}, 32'h0);
    chk(host.rdata, exp);
  endtask : rd

  task automatic cmd(input logic [7:0] c);
    wr(icd_pkg::OFF_CMD, {24'h0, c});
  endtask : cmd

  // Outputs are registered, so give them two edges to settle
  task automatic pin(ref logic got, input logic exp);
    repeat (2) @(posedge pclk);
    @(negedge pclk);
    chk({31'h0, got}, {31'h0, exp});
  endtask : pin

  task automatic end_sim;
    $display("errors %0d checks_done %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_sim

  initial begin
    repeat (20000) @(posedge pclk);
    errors++;
    end_sim();
  end

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    irq_source_strap = 1'b1;
    port_a_hi = 8'h00;
    errors = 0;
    checks_done = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rd(icd_pkg::OFF_IMR, 32'hff);
    rd(icd_pkg::OFF_IRR, 32'h00);
    cmd(8'h57);
    rd(icd_pkg::OFF_IRR, 32'hff);
    cmd(8'h4b);
    rd(icd_pkg::OFF_IRR, 32'hf7);
    for (int b = 0; b < 8; b++) begin
      cmd(8'h40);
      cmd(8'h58 | 8'(b));
      rd(icd_pkg::OFF_IRR, 32'h1 << b);
    end
    cmd(8'h27);
    rd(icd_pkg::OFF_IMR, 32'h00);
    cmd(8'h3a);
    rd(icd_pkg::OFF_IMR, 32'h04);
    cmd(8'h36);
    rd(icd_pkg::OFF_IMR, 32'hff);
    cmd(8'h2d);
    rd(icd_pkg::OFF_IMR, 32'hdf);
    cmd(8'h50);
    cmd(8'h1e);
    rd(icd_pkg::OFF_IRR, 32'hbf);
    rd(icd_pkg::OFF_IMR, 32'h9f);
    cmd(8'h13);
    rd(icd_pkg::OFF_IRR, 32'h00);
    rd(icd_pkg::OFF_IMR, 32'h00);
    cmd(8'h9f);
    rd(icd_pkg::OFF_MODE, 32'h1f);
    cmd(8'had);
    rd(icd_pkg::OFF_MODE, 32'hff);
    wr(icd_pkg::OFF_EVT, 32'h7);
    wr(icd_pkg::OFF_EVT_MSK, 32'h2);
    pin(irq, 1'b0);
    cmd(8'haf);
    rd(icd_pkg::OFF_MODE, 32'hff);
    pin(irq, 1'b1);
    wr(icd_pkg::OFF_EVT, 32'h2);
    pin(irq, 1'b0);
    cmd(8'h80);
    cmd(8'ha2);
    rd(icd_pkg::OFF_MODE, 32'h00);
    cmd(8'hb5);
    rd(icd_pkg::OFF_MODE, 32'h00);
    wr(icd_pkg::OFF_DATA, 32'h5a);
    rd(icd_pkg::OFF_IMR, 32'h5a);
    wr(icd_pkg::OFF_DATA, 32'h33);
    rd(icd_pkg::OFF_IMR, 32'h33);
    cmd(8'hcf);
    wr(icd_pkg::OFF_DATA, 32'h77);
    rd(icd_pkg::OFF_ACR, 32'h77);
    vec = '{8'h11, 8'h22, 8'h33, 8'h44};
    host.load_vectors(2'd2, 3'd5, vec);
    rd(icd_pkg::OFF_CFG, {21'h0, 3'd5, 6'h0, icd_pkg::ICD_SEL_VEC});
    cmd(8'h20);
    cmd(8'h5d);
    pin(int_req, 1'b1);
    cmd(8'ha1);
    pin(int_req, 1'b0);
    cmd(8'ha2);
    pin(int_req, 1'b1);
    for (int i = 0; i < 3; i++) begin
      rd(icd_pkg::OFF_IAK, {24'h0, vec[i]});
    end
    rd(icd_pkg::OFF_IAK, 32'h00);
    rd(icd_pkg::OFF_ISR, 32'h20);
    cmd(8'h7a);
    rd(icd_pkg::OFF_ISR, 32'h20);
    cmd(8'h6f);
    rd(icd_pkg::OFF_ISR, 32'h00);
    host.xfer(1'b1, BASE ^ 32'h100, 32'h36);
    chk({31'h0, host.err}, 32'h1);
    rd(icd_pkg::OFF_IMR, 32'h00);
    host.xfer(1'b0, BASE | 32'h40, 32'h0);
    chk({31'h0, host.err}, 32'h1);
    @(posedge pclk);
    port_a_hi <= 8'h40;
    rd(icd_pkg::OFF_IRR, 32'h00);
    port_a_hi <= 8'h44;
    rd(icd_pkg::OFF_IRR, 32'h04);
    irq_source_strap <= 1'b0;
    port_a_hi <= 8'h00;
    repeat (3) @(posedge pclk);
    port_a_hi <= 8'h40;
    rd(icd_pkg::OFF_IRR, 32'h44);
    end_sim();
  end
endmodule : tb
